// ### bench/gps_axis_sampler_chk.sv
`timescale 1ns/1ps
module gps_axis_sampler_chk #(
   parameter int WRAP_CYCLES = 2
) (
   input wire logic REF_CLK_IN,
   input wire logic NRST_IN,
   input wire logic [7:0] ADDRESS_IN,
   input wire logic READ_IN,
   input wire logic WRITE_IN,
   input wire logic [3:0] BYTEENABLE_IN,
   input wire logic [31:0] WRITEDATA_IN,
   input wire logic [31:0] READDATA_OUT,
   input wire logic WAITREQUEST_OUT,
   input wire logic FIRE_OUT,
   input wire logic IRQ_OUT
);
   logic acc_wr, host_start, mask_off;
   logic [31:0] since_r, since_nxt;
   assign acc_wr = WRITE_IN && !WAITREQUEST_OUT && BYTEENABLE_IN[0];
   // low or high position byte
   assign host_start = acc_wr && ADDRESS_IN[7:3] == 5'h07;
   assign mask_off = acc_wr && ADDRESS_IN[7:2] == gps_pkg::IDX_IRQ_MASK && !WRITEDATA_IN[0];
   // cycles since the last start pulse
   always_comb since_nxt = !NRST_IN ? 32'h0 : (FIRE_OUT ? 32'h1 : since_r + 32'h1);
   always_ff @(posedge REF_CLK_IN) since_r <= since_nxt;
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!NRST_IN);
   AST_WAIT_ONE: assert property ((READ_IN || WRITE_IN) && WAITREQUEST_OUT |=> !WAITREQUEST_OUT)
      else $error("no answer after request");
   AST_WAIT_SHORT: assert property (!WAITREQUEST_OUT |=> WAITREQUEST_OUT)
      else $error("answer longer than one cycle");
   AST_IDLE_WAIT: assert property (!READ_IN && !WRITE_IN |=> WAITREQUEST_OUT)
      else $error("answer without request");
   AST_RD_UPPER: assert property (READ_IN && !WAITREQUEST_OUT |-> READDATA_OUT[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_START_FIRE: assert property (host_start |-> ##[1:2] FIRE_OUT)
      else $error("start write gave no pulse");
   AST_FIRE_PULSE: assert property (FIRE_OUT |=> !FIRE_OUT)
      else $error("start pulse too long");
   AST_FIRE_CAUSE: assert property (FIRE_OUT |-> $past(host_start) || $past(host_start, 2) || since_r == WRAP_CYCLES)
      else $error("start pulse without cause");
   AST_IRQ_MASKED: assert property (mask_off |-> ##2 !IRQ_OUT)
      else $error("masked interrupt still high");
   cover property (host_start);
   cover property (FIRE_OUT && since_r == WRAP_CYCLES);
   cover property ($rose(IRQ_OUT));
endmodule : gps_axis_sampler_chk
bind gps_axis_sampler gps_axis_sampler_chk #(.WRAP_CYCLES(WRAP_CYCLES)) u_chk (.REF_CLK_IN(REF_CLK_IN),
   .NRST_IN(NRST_IN), .ADDRESS_IN(ADDRESS_IN), .READ_IN(READ_IN), .WRITE_IN(WRITE_IN), .IRQ_OUT(IRQ_OUT),
   .BYTEENABLE_IN(BYTEENABLE_IN), .WRITEDATA_IN(WRITEDATA_IN), .READDATA_OUT(READDATA_OUT),
   .WAITREQUEST_OUT(WAITREQUEST_OUT), .FIRE_OUT(FIRE_OUT));

// ### bench/gps_stick_model.sv
`timescale 1ns/1ps
// each axis line stays high for its charge time after a start pulse
module gps_stick_model (
   input wire logic clk_in,
   input wire logic fire_in,
   input wire logic [31:0] dur_us_in,
   output logic [3:0] level_out
);
   int left_r [4] = '{0, 0, 0, 0};
   always @(posedge clk_in) begin
      for (int i = 0; i < 4; i++) begin
         if (fire_in) left_r[i] <= 40 * dur_us_in[8*i +: 8];
         else if (left_r[i] > 0) left_r[i] <= left_r[i] - 1;
      end
   end
   always_comb for (int i = 0; i < 4; i++) level_out[i] = left_r[i] > 0;
endmodule : gps_stick_model

// ### bench/tb_gps_axis_sampler.sv
`timescale 1ns/1ps
module tb_gps_axis_sampler;
   logic clk, nrst, rd, wr, fire, irq, wait_o;
   logic [7:0] addr;
   logic [3:0] be, lvl, btn;
   logic [31:0] wd, rdata, dur;
   int errors = 0;
   int tests_run = 0;
   int nf;
   logic [7:0] row_ctrl [4] = '{8'h0f, 8'h1f, 8'h2f, 8'h3f};
   logic [7:0] row_cnt [4] = '{8'd10, 8'd20, 8'd30, 8'd40};
   gps_axis_sampler #(.WRAP_CYCLES(2000)) dut (.REF_CLK_IN(clk), .NRST_IN(nrst), .ADDRESS_IN(addr), .READ_IN(rd),
      .WRITE_IN(wr), .BYTEENABLE_IN(be), .WRITEDATA_IN(wd), .READDATA_OUT(rdata), .WAITREQUEST_OUT(wait_o),
      .AXIS_LEVEL_IN(lvl), .BUTTON_N_IN(btn), .FIRE_OUT(fire), .IRQ_OUT(irq));
   gps_stick_model u_stick (.clk_in(clk), .fire_in(fire), .dur_us_in(dur), .level_out(lvl));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task finish_test;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test
   task cmp(input string nm, input logic [15:0] e, input logic [15:0] g, input int tol);
      tests_run++;
      if ((^g === 1'bx) || g + tol < e || g > e + tol) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      @(posedge clk);
      addr <= a;
      rd <= !w;
      wr <= w;
      wd <= {24'h0, d};
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (wait_o === 1'b0) break;
      end
      q = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      if (n == 20) begin
         errors++;
         finish_test();
      end
   endtask : bus
   task wr8(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask : wr8
   task rdc(input string nm, input logic [7:0] a, input logic [7:0] e, input int tol);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      cmp(nm, {8'h00, e}, {8'h00, q}, tol);
   endtask : rdc
   task wait_done;
      logic [7:0] q;
      int n;
      for (n = 0; n < 2000; n++) begin
         bus(1'b0, 8'h34, 8'h00, q);
         if (q[gps_pkg::CTRL_DONE_BIT] === 1'b1) break;
      end
      if (n == 2000) begin
         errors++;
         finish_test();
      end
   endtask : wait_done
   initial begin
      nrst = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      be = 4'h1;
      addr = 8'h00;
      wd = 32'h0;
      btn = 4'hf;
      dur = {8'd40, 8'd30, 8'd20, 8'd10};
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      rdc("raw", 8'h30, 8'hf0, 0);
      rdc("ctrl", 8'h34, 8'hf0, 0);
      rdc("pos_lo", 8'h38, 8'hff, 0);
      rdc("pos_hi", 8'h3c, 8'hff, 0);
      rdc("unmapped", 8'h80, 8'h00, 0);
      wr8(8'h30, 8'h00);
      btn <= 4'h5;
      repeat (4) @(posedge clk);
      rdc("raw", 8'h30, 8'h50, 0);
      wr8(8'h34, 8'h0f);
      wr8(8'h38, 8'h5a);
      rdc("ctrl busy", 8'h34, 8'h0f, 0);
      wait_done();
      cmp("irq", 16'h0, {15'h0, irq}, 0);
      wr8(8'h44, 8'h01);
      repeat (3) @(posedge clk);
      cmp("irq", 16'h1, {15'h0, irq}, 0);
      wr8(8'h40, 8'h01);
      repeat (3) @(posedge clk);
      cmp("irq", 16'h0, {15'h0, irq}, 0);
      for (int i = 0; i < 4; i++) begin
         wr8(8'h34, row_ctrl[i]);
         rdc("ctrl", 8'h34, row_ctrl[i] | 8'h80, 0);
         rdc("pos_lo", 8'h38, row_cnt[i], 2);
         rdc("pos_hi", 8'h3c, 8'h00, 0);
      end
      dur <= {8'd45, 8'd35, 8'd25, 8'd15};
      wr8(8'h34, 8'h05);
      wr8(8'h3c, 8'h00);
      wait_done();
      rdc("pos_lo ax", 8'h38, 8'd15, 2);
      wr8(8'h34, 8'h15);
      rdc("pos_lo ay", 8'h38, 8'd20, 2);
      wr8(8'h34, 8'h4f);
      wr8(8'h38, 8'h00);
      nf = 0;
      repeat (4100) begin
         @(posedge clk);
         if (fire === 1'b1) nf++;
      end
      cmp("wrap starts", 16'd3, 16'(nf), 0);
      cmp("irq", 16'h1, {15'h0, irq}, 0);
      wr8(8'h44, 8'h00);
      repeat (2) @(posedge clk);
      cmp("irq masked", 16'h0, {15'h0, irq}, 0);
      wr8(8'h34, 8'h0f);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      cmp("irq reset", 16'h0, {15'h0, irq}, 0);
      rdc("ctrl reset", 8'h34, 8'hf0, 0);
      rdc("pos_hi reset", 8'h3c, 8'hff, 0);
      nf = 0;
      repeat (2100) begin
         @(posedge clk);
         if (fire === 1'b1) nf++;
      end
      cmp("wrap idle", 16'd0, 16'(nf), 0);
      finish_test();
   end
endmodule : tb_gps_axis_sampler

// ### core/gps_axis_sampler.sv
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module gps_axis_sampler #(
   parameter int WRAP_CYCLES = gps_pkg::WRAP_CYC
) (
   input wire logic REF_CLK_IN,
   input wire logic NRST_IN,
   input wire logic [7:0] ADDRESS_IN,
   input wire logic READ_IN,
   input wire logic WRITE_IN,
   input wire logic [3:0] BYTEENABLE_IN,
   input wire logic [31:0] WRITEDATA_IN,
   output logic [31:0] READDATA_OUT,
   output logic WAITREQUEST_OUT,
   input wire logic [3:0] AXIS_LEVEL_IN,
   input wire logic [3:0] BUTTON_N_IN,
   output logic FIRE_OUT,
   output logic IRQ_OUT
);
   // refuse wrap lengths the 25-bit counter cannot hold
   if (WRAP_CYCLES < 2 || WRAP_CYCLES > 33554431) begin : g_bad_wrap
      $error("WRAP_CYCLES out of range");
   end

   // two-flop synchronisers for pins
   logic [7:0] pin_s1_r;
   logic [7:0] pin_s2_r;
   always_ff @(posedge REF_CLK_IN) begin
      if (!NRST_IN) begin
         pin_s1_r <= {gps_pkg::BUTTON_RESET, gps_pkg::AXIS_RAW_RESET};
         pin_s2_r <= {gps_pkg::BUTTON_RESET, gps_pkg::AXIS_RAW_RESET};
      end else begin
         pin_s1_r <= {BUTTON_N_IN, AXIS_LEVEL_IN};
         pin_s2_r <= pin_s1_r;
      end
   end

   // bus slave state
   logic wait_r;
   logic wait_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [7:0] istat_r;
   logic [7:0] istat_nxt;
   logic [7:0] imask_r;
   logic [7:0] imask_nxt;
   logic irq_r;
   logic irq_nxt;
   // sampler state
   logic busy_r;
   logic busy_nxt;
   logic started_r;
   logic started_nxt;
   logic fire_r;
   logic fire_nxt;
   logic [2:0] arm_r;
   logic [2:0] arm_nxt;
   logic [5:0] tick_r;
   logic [5:0] tick_nxt;
   logic [24:0] wrap_r;
   logic [24:0] wrap_nxt;

   logic [5:0] idx;
   logic req;
   logic wr_go;
   logic start;
   logic tick;
   logic armed;
   logic all_done;
   logic done_evt;
   logic [3:0] axis_done;
   logic [15:0] axis_cnt [4];
   logic [15:0] sel_cnt;
   logic [1:0] sel;

   assign idx = ADDRESS_IN[7:2];
   assign req = READ_IN | WRITE_IN;
   assign wr_go = WRITE_IN & ~wait_r & BYTEENABLE_IN[0];
   assign sel = ctrl_r[gps_pkg::CTRL_SEL_LSB +: 2];
   assign sel_cnt = axis_cnt[sel];
   assign tick = (tick_r == 6'(gps_pkg::TICK_CYC - 1));
   assign armed = (arm_r == 3'(gps_pkg::ARM_CYC));

   generate
      for (genvar i = 0; i < 4; i++) begin : g_axis
         gps_axis_timer u_timer (
            .clk_in(REF_CLK_IN),
            .rst_n_in(NRST_IN),
            .start_in(start),
            .arm_in(armed),
            .enable_in(ctrl_r[gps_pkg::CTRL_MASK_LSB + i]),
            .tick_in(tick),
            .level_in(pin_s2_r[i]),
            .count_out(axis_cnt[i]),
            .done_out(axis_done[i])
         );
      end
   endgenerate

   assign all_done = &(axis_done | ~ctrl_r[gps_pkg::CTRL_MASK_LSB +: 4]);
   assign done_evt = busy_r & armed & all_done & ~start;

   // start by position byte write or wrap expiry after a manual start
   always_comb begin
      start = wr_go && (idx == gps_pkg::IDX_POS_LO || idx == gps_pkg::IDX_POS_HI);
      if (ctrl_r[gps_pkg::CTRL_WRAP_BIT] && started_r && wrap_r == 25'h0000000) begin
         start = 1'b1;
      end
   end

   // sampler sequencing
   always_comb begin
      busy_nxt = busy_r;
      started_nxt = started_r;
      fire_nxt = start;
      arm_nxt = arm_r;
      tick_nxt = tick ? 6'h00 : tick_r + 6'h01;
      wrap_nxt = (wrap_r == 25'h0000000) ? wrap_r : wrap_r - 25'h0000001;
      if (start) begin
         busy_nxt = 1'b1;
         started_nxt = 1'b1;
         arm_nxt = 3'h0;
         tick_nxt = 6'h00;
         wrap_nxt = 25'(WRAP_CYCLES - 1);
      end else begin
         if (!armed) begin
            arm_nxt = arm_r + 3'h1;
         end
         if (done_evt) begin
            busy_nxt = 1'b0;
         end
      end
   end

   // register file and bus answer
   always_comb begin
      wait_nxt = ~(req & wait_r);
      rdata_nxt = 32'h00000000;
      ctrl_nxt = ctrl_r;
      istat_nxt = istat_r;
      imask_nxt = imask_r;
      if (start) begin
         ctrl_nxt[gps_pkg::CTRL_DONE_BIT] = 1'b0;
      end
      if (done_evt) begin
         ctrl_nxt[gps_pkg::CTRL_DONE_BIT] = 1'b1;
      end
      if (READ_IN && wait_r) begin
         unique case (idx)
            gps_pkg::IDX_RAW: rdata_nxt = {24'h000000, pin_s2_r};
            gps_pkg::IDX_CTRL: rdata_nxt = {24'h000000, ctrl_r};
            gps_pkg::IDX_POS_LO: rdata_nxt = {24'h000000, sel_cnt[7:0]};
            gps_pkg::IDX_POS_HI: rdata_nxt = {24'h000000, sel_cnt[15:8]};
            gps_pkg::IDX_IRQ_STAT: rdata_nxt = {24'h000000, istat_r};
            gps_pkg::IDX_IRQ_MASK: rdata_nxt = {24'h000000, imask_r};
            default: rdata_nxt = 32'h00000000;
         endcase
      end
      if (wr_go) begin
         unique case (idx)
            gps_pkg::IDX_CTRL: begin
               ctrl_nxt[6:0] = WRITEDATA_IN[6:0];
            end
            gps_pkg::IDX_IRQ_STAT: istat_nxt = istat_r & ~WRITEDATA_IN[7:0];
            gps_pkg::IDX_IRQ_MASK: imask_nxt = WRITEDATA_IN[7:0];
            default: ctrl_nxt = ctrl_nxt; // raw and position bytes keep no write data
         endcase
      end
      if (done_evt) begin
         istat_nxt[gps_pkg::IRQ_DONE_BIT] = 1'b1;
      end
      irq_nxt = |(istat_nxt & imask_nxt);
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!NRST_IN) begin
         wait_r <= 1'b1;
         rdata_r <= 32'h00000000;
         ctrl_r <= gps_pkg::CTRL_RESET;
         istat_r <= 8'h00;
         imask_r <= 8'h00;
         irq_r <= 1'b0;
         busy_r <= 1'b0;
         started_r <= 1'b0;
         fire_r <= 1'b0;
         arm_r <= 3'(gps_pkg::ARM_CYC);
         tick_r <= 6'h00;
         wrap_r <= 25'h0000000;
      end else begin
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
         ctrl_r <= ctrl_nxt;
         istat_r <= istat_nxt;
         imask_r <= imask_nxt;
         irq_r <= irq_nxt;
         busy_r <= busy_nxt;
         started_r <= started_nxt;
         fire_r <= fire_nxt;
         arm_r <= arm_nxt;
         tick_r <= tick_nxt;
         wrap_r <= wrap_nxt;
      end
   end

   assign READDATA_OUT = rdata_r;
   assign WAITREQUEST_OUT = wait_r;
   assign FIRE_OUT = fire_r;
   assign IRQ_OUT = irq_r;
endmodule : gps_axis_sampler

// ### core/gps_axis_timer.sv
`timescale 1ns/1ps
module gps_axis_timer (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   input wire logic arm_in,
   input wire logic enable_in,
   input wire logic tick_in,
   input wire logic level_in,
   output logic [15:0] count_out,
   output logic done_out
);
   logic [15:0] count_r;
   logic [15:0] count_nxt;
   logic done_r;
   logic done_nxt;

   always_comb begin
      count_nxt = count_r;
      done_nxt = done_r;
      if (start_in) begin
         if (enable_in) begin
            count_nxt = 16'h0000;
            done_nxt = 1'b0;
         end
      end else if (!done_r && arm_in && enable_in) begin
         if (!level_in || count_r == 16'hffff) begin
            done_nxt = 1'b1;
         end else if (tick_in) begin
            count_nxt = count_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         count_r <= gps_pkg::COUNT_RESET;
         done_r <= 1'b1;
      end else begin
         count_r <= count_nxt;
         done_r <= done_nxt;
      end
   end

   assign count_out = count_r;
   assign done_out = done_r;
endmodule : gps_axis_timer

// ### core/gps_pkg.sv
package gps_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_RAW = 6'h0c;
   localparam logic [5:0] IDX_CTRL = 6'h0d;
   localparam logic [5:0] IDX_POS_LO = 6'h0e;
   localparam logic [5:0] IDX_POS_HI = 6'h0f;
   localparam logic [5:0] IDX_IRQ_STAT = 6'h10;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h11;
   // control register fields
   localparam int CTRL_DONE_BIT = 7;
   localparam int CTRL_WRAP_BIT = 6;
   localparam int CTRL_SEL_LSB = 4;
   localparam int CTRL_MASK_LSB = 0;
   localparam logic [7:0] CTRL_RESET = 8'hf0;
   localparam logic [7:0] POS_RESET = 8'hff;
   localparam logic [3:0] BUTTON_RESET = 4'hf;
   localparam logic [3:0] AXIS_RAW_RESET = 4'h0;
   localparam logic [15:0] COUNT_RESET = 16'hffff;
   localparam int IRQ_DONE_BIT = 0;
   // timing
   localparam int CLK_HZ = 40000000;
   localparam int WRAP_MS = 16;
   localparam int WRAP_CYC = (CLK_HZ / 1000) * WRAP_MS;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = (TICK_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int ARM_CYC = 4;
endpackage : gps_pkg
